/* msl_consts.svh */
// Constants for the motion stop, limit and wrap supervisor
`ifndef MSL_CONSTS_SVH
`define MSL_CONSTS_SVH

`define MSL_POS_W          24
`define MSL_ROT_W          16
`define MSL_POS_MAX        24'h7FFFFF
`define MSL_POS_MIN        24'h800000
`define MSL_WRAP_MIN       24'h000001
`define MSL_WRAP_DEF       24'h0003E8
`define MSL_STOP_DEF       2'h0
`define MSL_OT_EN_DEF      1'h1
`define MSL_WRAP_EN_DEF    1'h0
`define MSL_HOLD_DEF       1'h0
`define MSL_STEP_MDEG      720
`define MSL_REV_MDEG       360000
`define MSL_DECEL_STEP     16'h0001

`define MSL_A_STOP_ACT     4'h0
`define MSL_A_OT_EN        4'h1
`define MSL_A_POS_LIM      4'h2
`define MSL_A_NEG_LIM      4'h3
`define MSL_A_WRAP_EN      4'h4
`define MSL_A_WRAP_RANGE   4'h5
`define MSL_A_HOLD_SEL     4'h6
`define MSL_A_STATUS       4'h7
`define MSL_A_CMD_POS      4'h8
`define MSL_A_ROT_CNT      4'h9

`define MSL_ST_COORD       0
`define MSL_ST_OT_POS      1
`define MSL_ST_OT_NEG      2
`define MSL_ST_CUR_ON      3
`define MSL_ST_HOLD        4
`define MSL_ST_MOVING      5

`endif

/* msl_host_model.sv */
// Host controller model driving the discrete inputs
`timescale 1ns/1ps
`default_nettype none
module msl_host_model (
  // Clock
  input  wire logic       clk,
  // Bench commands
  input  wire logic       want_run,
  input  wire logic       want_stop,
  input  wire logic [2:0] sw_set,
  // Discrete inputs of the device
  output var  logic       run_req,
  output var  logic       stop_req,
  output var  logic       mode_switch_a,
  output var  logic       mode_switch_b,
  output var  logic       mode_switch_d
);
  always @(posedge clk) begin
    run_req <= want_run;
    stop_req <= want_stop;
    // Switches move only when the bench says so
    {mode_switch_a, mode_switch_b, mode_switch_d} <= sw_set;
  end
endmodule // msl_host_model
`default_nettype wire

/* msl_mode_latch.sv */
// Power-up capture of the control-mode switches
`timescale 1ns/1ps
`default_nettype none
module msl_mode_latch
  import msl_pkg::*;
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // Switches
  input  wire logic          mode_switch_a,
  input  wire logic          mode_switch_b,
  input  wire logic          mode_switch_d,
  // Latched mode
  output msl_pkg::msl_mode_t mode,
  output logic               mode_valid
);
  typedef struct packed {
    msl_mode_t mode;
    logic      done;
  } msl_ml_state_t;

  msl_ml_state_t s_r;
  msl_ml_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (!s_r.done) begin
      s_nxt.done = 1'b1;
      if (mode_switch_b && mode_switch_d) begin
        s_nxt.mode = mode_switch_a ? MSL_MODE_LEGACY_POS : MSL_MODE_LEGACY_SPEED;
      end else begin
        s_nxt.mode = MSL_MODE_NATIVE;
      end
    end
  end

  // Taken once after reset release, later changes ignored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '{mode: MSL_MODE_NATIVE, done: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign mode       = s_r.mode;
  assign mode_valid = s_r.done;
endmodule // msl_mode_latch
`default_nettype wire

/* msl_pkg.sv */
// Types for the motion stop, limit and wrap supervisor
package msl_pkg;
  `include "msl_consts.svh"

  typedef enum logic [1:0] {
    MSL_STOP_IMM,
    MSL_STOP_DEC,
    MSL_STOP_IMM_OFF,
    MSL_STOP_DEC_OFF
  } msl_stop_t;

  typedef enum logic [1:0] {
    MSL_MODE_NATIVE,
    MSL_MODE_LEGACY_SPEED,
    MSL_MODE_LEGACY_POS
  } msl_mode_t;

  typedef enum logic [1:0] {
    MSL_RUN,
    MSL_DECEL,
    MSL_HALT
  } msl_motion_t;
endpackage : msl_pkg

/* msl_supervisor.sv */
// Motion stop, software limit and wrap supervisor
// Summary of operation
// - Stop request while moving halts the motor by the selected stop action.
// - Stop action: 0 immediate, 1 decel, 2 immediate+off, 3 decel+off; default 0.
// - Software limits are checked only once a position coordinate exists.
// - Overtravel enable: 0 off, 1 on; default 1.
// - Positive limit is signed 24-bit steps, default +8,388,607.
// - Negative limit is signed 24-bit steps, default -8,388,608.
// - One step equals 0.72 degrees of shaft rotation.
// - Home return or position preset establishes the coordinate.
// - Wrap on: passing the range clears position and rotation count.
// - Wrap on: command position stays within zero to range minus one; here only steps are folded in, a preset loads any value unchecked.
// - Wrap enable: 0 off, 1 on; default 0.
// - Wrap range 1 to 8,388,607 steps, default 1000.
// - Wrap on forces overtravel detection off.
// - Mode switches are sampled only at power-up.
// - A off with B,D on: legacy speed; A,B,D on: legacy position.
// - After-stop hold: 0 free shaft, 1 servo lock; default 0.
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "msl_consts.svh"
module msl_supervisor (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // Register port
  input  wire logic [3:0]                reg_addr,
  input  wire logic [31:0]               reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [31:0]               reg_rdata,
  // Host discrete inputs
  input  wire logic                      stop_req,
  input  wire logic                      mode_switch_a,
  input  wire logic                      mode_switch_b,
  input  wire logic                      mode_switch_d,
  // Motion engine interface
  input  wire logic                      step_valid,
  input  wire logic                      step_dir_neg,
  input  wire logic                      home_done,
  input  wire logic                      preset_req,
  input  wire logic [`MSL_POS_W-1:0]     preset_value,
  input  wire logic                      run_req,
  // Supervisor outputs
  output logic signed [`MSL_POS_W-1:0]   cmd_pos,
  output logic      [`MSL_ROT_W-1:0]     rot_count,
  output logic                           coord_set,
  output logic                           ot_pos,
  output logic                           ot_neg,
  output logic                           motion_enable,
  output logic                           decel_active,
  output logic                           current_on,
  output logic                           servo_lock,
  output msl_pkg::msl_mode_t             ctrl_mode,
  output logic                           mode_valid
);
  import msl_pkg::*;

  localparam int STEP_MDEG = `MSL_STEP_MDEG; // 0.72 degree per step
  localparam int DECEL_CNT = 8;
  localparam int REV_STEPS = `MSL_REV_MDEG / STEP_MDEG; // Steps per shaft turn
  localparam int REV_W     = $clog2(REV_STEPS);
  localparam int ROT_W     = `MSL_ROT_W;

  typedef struct packed {
    logic [1:0]                    stop_act;
    logic                          ot_en;
    logic signed [`MSL_POS_W-1:0]  pos_lim;
    logic signed [`MSL_POS_W-1:0]  neg_lim;
    logic                          wrap_en;
    logic [`MSL_POS_W-1:0]         wrap_range;
    logic                          hold_sel;
    logic signed [`MSL_POS_W-1:0]  pos;
    logic [`MSL_ROT_W-1:0]         rot;
    logic [REV_W-1:0]              rev;
    logic                          coord;
    logic                          ot_p;
    logic                          ot_n;
    logic                          cur_on;
    msl_motion_t                   motion;
    logic [3:0]                    dec_cnt;
    logic                          stop_d;
    logic [31:0]                   rdata;
  } msl_state_t;

  msl_state_t s_r;
  msl_state_t s_nxt;

  logic                         ot_active;
  logic signed [`MSL_POS_W:0]   pos_step;
  logic                         moving;
  logic [`MSL_POS_W-1:0]        wr_val;
  logic                         rev_carry;
  logic [REV_W-1:0]             rev_step;
  logic [`MSL_ROT_W-1:0]        rot_step;

  msl_mode_latch u_mode (
    .clk           (clk),
    .rst           (rst),
    .mode_switch_a (mode_switch_a),
    .mode_switch_b (mode_switch_b),
    .mode_switch_d (mode_switch_d),
    .mode          (ctrl_mode),
    .mode_valid    (mode_valid)
  );

  // Wrap overrides limits; no coordinate means no check
  assign ot_active = s_r.ot_en && !s_r.wrap_en && s_r.coord;
  assign moving    = (s_r.motion != MSL_HALT);
  assign wr_val    = reg_wdata[`MSL_POS_W-1:0];
  assign pos_step  = step_dir_neg ? ({s_r.pos[`MSL_POS_W-1], s_r.pos} - 25'sd1)
                                  : ({s_r.pos[`MSL_POS_W-1], s_r.pos} + 25'sd1);
  // Whole shaft turns carry into the rotation count
  assign rev_carry = step_dir_neg ? (s_r.rev == '0) : (s_r.rev == REV_W'(REV_STEPS - 1));
  assign rev_step  = rev_carry ? (step_dir_neg ? REV_W'(REV_STEPS - 1) : '0)
                               : (step_dir_neg ? s_r.rev - REV_W'(1) : s_r.rev + REV_W'(1));
  assign rot_step  = !rev_carry ? s_r.rot
                                : (step_dir_neg ? s_r.rot - ROT_W'(1) : s_r.rot + ROT_W'(1));

  always_comb begin
    s_nxt        = s_r;
    s_nxt.stop_d = stop_req;
    s_nxt.rdata  = 32'h00000000;

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        `MSL_A_STOP_ACT:   s_nxt.stop_act = reg_wdata[1:0];
        `MSL_A_OT_EN:      s_nxt.ot_en = reg_wdata[0];
        `MSL_A_POS_LIM:    s_nxt.pos_lim = wr_val;
        `MSL_A_NEG_LIM:    s_nxt.neg_lim = wr_val;
        `MSL_A_WRAP_EN:    s_nxt.wrap_en = reg_wdata[0];
        `MSL_A_WRAP_RANGE: begin
          // Range below one or above max is refused
          if (wr_val >= `MSL_WRAP_MIN && !wr_val[`MSL_POS_W-1]) begin
            s_nxt.wrap_range = wr_val;
          end
        end
        `MSL_A_HOLD_SEL:   s_nxt.hold_sel = reg_wdata[0];
        default: ;
      endcase
    end

    // Register reads
    if (reg_rd) begin
      case (reg_addr)
        `MSL_A_STOP_ACT:   s_nxt.rdata = {30'h0, s_r.stop_act};
        `MSL_A_OT_EN:      s_nxt.rdata = {31'h0, s_r.ot_en};
        `MSL_A_POS_LIM:    s_nxt.rdata = {{8{s_r.pos_lim[`MSL_POS_W-1]}}, s_r.pos_lim};
        `MSL_A_NEG_LIM:    s_nxt.rdata = {{8{s_r.neg_lim[`MSL_POS_W-1]}}, s_r.neg_lim};
        `MSL_A_WRAP_EN:    s_nxt.rdata = {31'h0, s_r.wrap_en};
        `MSL_A_WRAP_RANGE: s_nxt.rdata = {8'h0, s_r.wrap_range};
        `MSL_A_HOLD_SEL:   s_nxt.rdata = {31'h0, s_r.hold_sel};
        `MSL_A_STATUS: begin
          s_nxt.rdata[`MSL_ST_COORD]  = s_r.coord;
          s_nxt.rdata[`MSL_ST_OT_POS] = s_r.ot_p;
          s_nxt.rdata[`MSL_ST_OT_NEG] = s_r.ot_n;
          s_nxt.rdata[`MSL_ST_CUR_ON] = s_r.cur_on;
          s_nxt.rdata[`MSL_ST_HOLD]   = (s_r.motion == MSL_HALT) && s_r.hold_sel && s_r.cur_on;
          s_nxt.rdata[`MSL_ST_MOVING] = moving;
        end
        `MSL_A_CMD_POS:    s_nxt.rdata = {{8{s_r.pos[`MSL_POS_W-1]}}, s_r.pos};
        `MSL_A_ROT_CNT:    s_nxt.rdata = {16'h0, s_r.rot};
        default:           s_nxt.rdata = 32'h00000000;
      endcase
    end

    // Position tracking
    if (home_done) begin
      s_nxt.pos   = '0;
      s_nxt.rot   = '0;
      s_nxt.rev   = '0;
      s_nxt.coord = 1'b1;
    end else if (preset_req) begin
      s_nxt.pos   = preset_value;
      s_nxt.coord = 1'b1;
    end else if (step_valid && moving) begin
      if (s_r.wrap_en) begin
        // Leaving 0..range-1 clears position and rotation count
        if (pos_step >= $signed({1'b0, s_r.wrap_range}) || pos_step < 25'sd0) begin
          s_nxt.pos = '0;
          s_nxt.rot = '0;
          s_nxt.rev = '0;
        end else begin
          s_nxt.pos = pos_step[`MSL_POS_W-1:0];
          s_nxt.rev = rev_step;
          s_nxt.rot = rot_step;
        end
      end else if (!(ot_active && ((!step_dir_neg && s_r.ot_p) ||
                                   (step_dir_neg && s_r.ot_n)))) begin
        s_nxt.pos = pos_step[`MSL_POS_W-1:0];
        s_nxt.rev = rev_step;
        s_nxt.rot = rot_step;
      end
    end

    // Limit flags
    s_nxt.ot_p = ot_active && (s_nxt.pos >= s_r.pos_lim);
    s_nxt.ot_n = ot_active && (s_nxt.pos <= s_r.neg_lim);

    // Motion and stop sequencing
    case (s_r.motion)
      MSL_RUN: begin
        if (stop_req && !s_r.stop_d) begin
          // Stop action picks decel and current removal
          case (msl_stop_t'(s_r.stop_act))
            MSL_STOP_IMM:     s_nxt.motion = MSL_HALT;
            MSL_STOP_DEC:     s_nxt.motion = MSL_DECEL;
            MSL_STOP_IMM_OFF: begin
              s_nxt.motion = MSL_HALT;
              s_nxt.cur_on = 1'b0;
            end
            MSL_STOP_DEC_OFF: s_nxt.motion = MSL_DECEL;
            default:          s_nxt.motion = MSL_HALT;
          endcase
          s_nxt.dec_cnt = 4'(DECEL_CNT - 1);
        end else if (!run_req) begin
          s_nxt.motion = MSL_HALT;
        end
      end
      MSL_DECEL: begin
        if (s_r.dec_cnt == 4'h0) begin
          s_nxt.motion = MSL_HALT;
          if (s_r.stop_act == 2'(MSL_STOP_DEC_OFF)) begin
            s_nxt.cur_on = 1'b0;
          end
        end else begin
          s_nxt.dec_cnt = s_r.dec_cnt - 4'h1;
        end
      end
      MSL_HALT: begin
        // A stop at rest changes nothing
        if (run_req && !stop_req) begin
          s_nxt.motion = MSL_RUN;
          s_nxt.cur_on = 1'b1;
        end
      end
      default: s_nxt.motion = MSL_HALT;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '{stop_act:   `MSL_STOP_DEF,
               ot_en:      `MSL_OT_EN_DEF,
               pos_lim:    `MSL_POS_MAX,
               neg_lim:    `MSL_POS_MIN,
               wrap_en:    `MSL_WRAP_EN_DEF,
               wrap_range: `MSL_WRAP_DEF,
               hold_sel:   `MSL_HOLD_DEF,
               pos:        '0,
               rot:        '0,
               rev:        '0,
               coord:      1'b0,
               ot_p:       1'b0,
               ot_n:       1'b0,
               cur_on:     1'b0,
               motion:     MSL_HALT,
               dec_cnt:    4'h0,
               stop_d:     1'b0,
               rdata:      32'h00000000};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata     = s_r.rdata;
  assign cmd_pos       = s_r.pos;
  assign rot_count     = s_r.rot;
  assign coord_set     = s_r.coord;
  assign ot_pos        = s_r.ot_p;
  assign ot_neg        = s_r.ot_n;
  assign motion_enable = (s_r.motion == MSL_RUN);
  assign decel_active  = (s_r.motion == MSL_DECEL);
  assign current_on    = s_r.cur_on;
  // Holding force only when halted with current and lock chosen
  assign servo_lock    = (s_r.motion == MSL_HALT) && s_r.hold_sel && s_r.cur_on;
endmodule // msl_supervisor
`default_nettype wire

/* msl_supervisor_checker.sv */
// Port assertions for the motion supervisor
`timescale 1ns/1ps
`default_nettype none
`include "msl_consts.svh"
module msl_supervisor_checker
  import msl_pkg::*;
(
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    rst,
  // Inputs
  input wire logic                    stop_req,
  input wire logic                    mode_switch_a,
  input wire logic                    mode_switch_b,
  input wire logic                    mode_switch_d,
  input wire logic                    home_done,
  input wire logic                    preset_req,
  input wire logic [`MSL_POS_W-1:0]   preset_value,
  // Outputs
  input wire logic signed [`MSL_POS_W-1:0] cmd_pos,
  input wire logic [`MSL_ROT_W-1:0]   rot_count,
  input wire logic                    coord_set,
  input wire logic                    ot_pos,
  input wire logic                    ot_neg,
  input wire logic                    motion_enable,
  input wire logic                    decel_active,
  input wire logic                    current_on,
  input wire logic                    servo_lock,
  input wire msl_pkg::msl_mode_t      ctrl_mode,
  input wire logic                    mode_valid
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  wire at_rest = !motion_enable && !decel_active;

  a_stop_halts: assert property (motion_enable && $rose(stop_req) |=> !motion_enable)
    else $error("stop request did not end run");
  a_decel_span: assert property ($rose(decel_active) |-> decel_active[*8] ##1 !decel_active)
    else $error("deceleration length wrong");
  a_rest_ignore: assert property (at_rest && stop_req |=> $stable(current_on) && !motion_enable)
    else $error("stop at rest changed state");
  a_limit_gate: assert property (!coord_set |-> !ot_pos && !ot_neg)
    else $error("overtravel without coordinate");
  a_home_clear: assert property (home_done |=> coord_set && cmd_pos == 0 && rot_count == 0)
    else $error("home return did not clear position");
  a_preset_load: assert property (preset_req && !home_done |=>
    coord_set && cmd_pos == $signed($past(preset_value)))
    else $error("preset not loaded");
  a_mode_frozen: assert property (mode_valid |=> mode_valid && $stable(ctrl_mode))
    else $error("mode changed after capture");
  a_mode_decode: assert property ($rose(mode_valid) |-> ctrl_mode ==
    (($past(mode_switch_b) && $past(mode_switch_d)) ? ($past(mode_switch_a) ?
    MSL_MODE_LEGACY_POS : MSL_MODE_LEGACY_SPEED) : MSL_MODE_NATIVE))
    else $error("mode decode wrong");
  a_lock_rest: assert property (servo_lock |-> at_rest && current_on)
    else $error("servo lock outside rest");

  c_decel: cover property ($rose(decel_active));
  c_lock: cover property ($rose(servo_lock));
  c_ot: cover property ($rose(ot_pos));
endmodule // msl_supervisor_checker

bind msl_supervisor msl_supervisor_checker u_msl_supervisor_checker (
  .clk(clk), .rst(rst), .stop_req(stop_req), .mode_switch_a(mode_switch_a),
  .mode_switch_b(mode_switch_b), .mode_switch_d(mode_switch_d), .home_done(home_done),
  .preset_req(preset_req), .preset_value(preset_value), .cmd_pos(cmd_pos),
  .rot_count(rot_count), .coord_set(coord_set), .ot_pos(ot_pos), .ot_neg(ot_neg),
  .motion_enable(motion_enable), .decel_active(decel_active), .current_on(current_on),
  .servo_lock(servo_lock), .ctrl_mode(ctrl_mode), .mode_valid(mode_valid));
`default_nettype wire

/* msl_supervisor_test.sv */
// Self-checking bench for the motion supervisor
`timescale 1ns/1ps
`default_nettype none
`include "msl_consts.svh"
module msl_supervisor_test;
  import msl_pkg::*;
  logic clk, rst, reg_wr, reg_rd, step_valid, step_dir_neg, home_done, preset_req;
  logic want_run, want_stop, run_req, stop_req, sw_a, sw_b, sw_d;
  logic [2:0] sw_set;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [`MSL_POS_W-1:0] preset_value;
  logic signed [`MSL_POS_W-1:0] cmd_pos;
  logic [`MSL_ROT_W-1:0] rot_count;
  logic coord_set, ot_pos, ot_neg, motion_enable, decel_active, current_on;
  logic servo_lock, mode_valid;
  msl_mode_t ctrl_mode;
  int n_errors = 0;
  int tests_run = 0;
  logic [31:0] dflt [7] = '{32'h0, 32'h1, 32'h007FFFFF, 32'hFF800000, 32'h0, 32'h3E8, 32'h0};

  msl_host_model u_msl_host_model (.clk(clk), .want_run(want_run), .want_stop(want_stop),
    .sw_set(sw_set), .run_req(run_req), .stop_req(stop_req), .mode_switch_a(sw_a),
    .mode_switch_b(sw_b), .mode_switch_d(sw_d));
  msl_supervisor u_msl_supervisor (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .stop_req(stop_req), .mode_switch_a(sw_a), .mode_switch_b(sw_b), .mode_switch_d(sw_d),
    .step_valid(step_valid), .step_dir_neg(step_dir_neg), .home_done(home_done),
    .preset_req(preset_req), .preset_value(preset_value), .run_req(run_req),
    .cmd_pos(cmd_pos), .rot_count(rot_count), .coord_set(coord_set), .ot_pos(ot_pos),
    .ot_neg(ot_neg), .motion_enable(motion_enable), .decel_active(decel_active),
    .current_on(current_on), .servo_lock(servo_lock), .ctrl_mode(ctrl_mode),
    .mode_valid(mode_valid));

  task automatic finish_test();
    if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string nm);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, exp, reg_rdata);
  endtask
  task automatic step(input logic neg);
    @(posedge clk);
    step_valid <= 1'b1;
    step_dir_neg <= neg;
    @(posedge clk);
    step_valid <= 1'b0;
    #1;
  endtask
  task automatic evt(input bit home);
    @(posedge clk);
    if (home) home_done <= 1'b1;
    else preset_req <= 1'b1;
    @(posedge clk);
    home_done <= 1'b0;
    preset_req <= 1'b0;
    #1;
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    cyc(2);
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #(40000 * 5);
    n_errors++;
    finish_test();
  end
  initial begin
    {rst, reg_wr, reg_rd, step_valid, step_dir_neg, home_done, preset_req} = 7'h7F;
    {reg_wr, reg_rd, step_valid, step_dir_neg, home_done, preset_req} = 6'h00;
    {want_run, want_stop, reg_addr, reg_wdata, preset_value} = '0;
    sw_set = 3'h7;
    do_reset();
    chk("ctrl_mode", 32'(MSL_MODE_LEGACY_POS), 32'(ctrl_mode));
    @(posedge clk);
    sw_set <= 3'h0;
    cyc(4);
    chk("ctrl_mode", 32'(MSL_MODE_LEGACY_POS), 32'(ctrl_mode));
    @(posedge clk);
    sw_set <= 3'h3;
    do_reset();
    chk("ctrl_mode", 32'(MSL_MODE_LEGACY_SPEED), 32'(ctrl_mode));
    for (int i = 0; i < 7; i++) rd(i[3:0], dflt[i], "reg default");
    rd(4'hA, 32'h0, "unmapped");
    wr(4'h2, 32'h2);
    @(posedge clk);
    want_run <= 1'b1;
    cyc(4);
    repeat (3) step(1'b0);
    chk("cmd_pos", 32'h3, 32'(cmd_pos));
    chk("ot_pos", 32'h0, ot_pos);
    @(posedge clk);
    preset_value <= 24'h000005;
    evt(1'b0);
    chk("cmd_pos", 32'h5, 32'(cmd_pos));
    cyc(1);
    chk("ot_pos", 32'h1, ot_pos);
    rd(4'h7, 32'h2B, "status");
    wr(4'h5, 32'h0);
    rd(4'h5, 32'h3E8, "wrap range");
    wr(4'h5, 32'h4);
    wr(4'h3, 32'hFFFFFF);
    evt(1'b1);
    chk("coord_set", 32'h1, coord_set);
    repeat (2) step(1'b1);
    chk("cmd_pos", 32'hFFFFFFFF, 32'(cmd_pos));
    chk("ot_neg", 32'h1, ot_neg);
    chk("rot_count", 32'hFFFF, rot_count);
    wr(4'h4, 32'h1);
    step(1'b1);
    chk("cmd_pos", 32'h0, 32'(cmd_pos));
    chk("rot_count", 32'h0, rot_count);
    chk("ot_neg", 32'h0, ot_neg);
    repeat (3) step(1'b0);
    chk("cmd_pos", 32'h3, 32'(cmd_pos));
    chk("ot_pos", 32'h0, ot_pos);
    step(1'b0);
    chk("cmd_pos", 32'h0, 32'(cmd_pos));
    chk("rot_count", 32'h0, rot_count);
    step(1'b1);
    chk("cmd_pos", 32'h0, 32'(cmd_pos));
    @(posedge clk);
    want_run <= 1'b0;
    wr(4'h6, 32'h1);
    for (int a = 3; a >= 0; a--) begin
      wr(4'h0, a);
      @(posedge clk);
      want_run <= 1'b1;
      cyc(4);
      chk("motion_enable", 32'h1, motion_enable);
      @(posedge clk);
      want_stop <= 1'b1;
      cyc(4);
      chk("decel_active", a % 2, decel_active);
      chk("motion_enable", 32'h0, motion_enable);
      cyc(10);
      chk("current_on", a < 2, current_on);
      chk("servo_lock", a < 2, servo_lock);
      @(posedge clk);
      want_run <= 1'b0;
      want_stop <= 1'b0;
    end
    @(posedge clk);
    want_stop <= 1'b1;
    cyc(4);
    chk("current_on", 32'h1, current_on);
    chk("motion_enable", 32'h0, motion_enable);
    finish_test();
  end
endmodule // msl_supervisor_test
`default_nettype wire
